//--- hw/cps_pkg.sv
// Package for the charger input power sequencer: register map, field layouts, timing.
// Assumes one 50 MHz system clock and a plain strobe register port.
package cps_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_KHZ = 50_000;
    // Slow time base tick period.
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
    // Sequencer delays in milliseconds, counted in ticks.
    localparam int BIAS_DLY_MS = 220;
    localparam int BIAS_DLY_MIN_MS = 100;
    localparam int RETRY_MS = 2000;
    localparam int BOOST_DLY_MS = 30;
    localparam int DET_MS = 1;

    localparam logic [3:0] ADDR_CTRL0 = 4'h0;
    localparam logic [3:0] ADDR_CFG1 = 4'h1;
    localparam logic [3:0] ADDR_BOOST = 4'h6;
    localparam logic [3:0] ADDR_MISC = 4'h7;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_FAULT = 4'h9;

    // Control register 0 fields.
    localparam int HIZ_BIT = 7;
    localparam logic [3:0] VIN_LIM_RST = 4'h6;
    // Current limit codes.
    localparam logic [2:0] CURRENT_LIMIT_PIN_100 = 3'h0;
    localparam logic [2:0] CURRENT_LIMIT_PIN_500 = 3'h2;
    localparam logic [2:0] CURRENT_LIMIT_PIN_3A = 3'h7;
    localparam logic [2:0] CURRENT_LIMIT_PIN_RST = 3'h0;
    // Config register 1, boost register and misc register fields.
    localparam logic [1:0] CHG_CFG_RST = 2'h1;
    localparam logic [1:0] CHG_CFG_BOOST = 2'h2;
    localparam logic [2:0] SYSMIN_RST = 3'h5;
    localparam logic [1:0] TEMP_BAND_OFF = 2'h3;
    localparam logic [3:0] BOOST_VOLTAGE_FIELD_RST = 4'h7;
    localparam int FORCE_DET_BIT = 7;
    // Source type encodings, status and fault bit positions.
    localparam logic [1:0] SRC_UNKNOWN = 2'h0;
    localparam logic [1:0] SRC_USB = 2'h1;
    localparam logic [1:0] SRC_ADAPTER = 2'h2;
    localparam logic [1:0] SRC_OTG = 2'h3;
    localparam int ST_PG_BIT = 2;
    localparam int ST_DPM_BIT = 3;
    localparam int ST_SYSMIN_BIT = 0;
    localparam int FLT_BOOST_BIT = 6;
    localparam int FLT_IN_LSB = 4;

    typedef struct packed {
        logic uvlo_ok;
        logic above_sleep;
        logic below_ovp;
        logic src_good;
        logic bat_good;
        logic bat_above_low;
        logic bat_depleted;
        logic sys_below_bat;
        logic sys_above_2v2;
        logic at_sys_min;
        logic over_input_i;
        logic below_vin_lim;
        logic temp_ok;
        logic boost_fault;
        logic watchdog_to;
        logic charge_en;
    } cps_sense_t;

    typedef struct packed {
        logic bias_en;
        logic test_load;
        logic conv_en;
        logic boost_en;
        logic batt_sw_on;
        logic boost_1a5;
        logic [3:0] boost_v;
        logic [2:0] sys_min;
        logic [2:0] current_limit_pin_eff;
        logic [3:0] vin_lim;
        logic cut_charge;
    } cps_drive_t;
endpackage

//--- hw/cps_seq.sv
// Input power sequencer of a single-cell charger: bias, source check, limit detection,
// high-impedance handling, soft-start, boost enable and status reporting.
// Assumes analog comparator levels arrive synchronous to the system clock.
// Functional notes
// - Bias on after undervoltage release, sleep margin and 220 ms delay.
// - Outside boost, any failing bias condition keeps high-impedance state, bias off.
// - Start converter only below overvoltage and above poor-source level under test load.
// - Qualified source sets input-good status, drives low input-good pin, interrupts.
// - Failed poor-source check is retried every 2 seconds.
// - After input good, always run limit detection unless held in host-mode high-impedance.
// - Detection writes source type and limit; host may overwrite the limit.
// - Port-select high: 100 or 500 mA by OTG, type 01; low: 3 A, type 10.
// - 100 mA host with good battery enters high-impedance, sets control bit.
// - Host-mode high-impedance persists until host writes the control bit to 0, a watchdog timeout or a boost request.
// - Default mode clears control bit on removal and redetects on new source.
// - Force bit or watchdog redetects at 100 mA; bit self-clears.
// - After limit set, switching starts; battery switch off if charging disabled and not in supplement mode.
// - Soft-start forces 100 mA below 2.2 V, then lower of register and pin.
// - Boost after 30 ms with battery, sleep, OTG, config and temperature conditions.
// - Boost reports type 11, chooses 1 or 1.5 A, four-bit output voltage.
// - Boost fault sets its fault bit and interrupts.
// - Minimum system field defaults to 3.5 V; status bit while regulating there.
// - Current over limit or voltage under limit sets power-limit-loop bit, cuts charge.
// - Supplement mode on when system below battery, off at battery depletion.
// - Source type: 00 unknown, 01 USB host, 10 adapter, 11 OTG.
// - Fault bits latch; a read returns and clears them.
`timescale 1ns/1ps
module cps_seq
    import cps_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register port.
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Pins and analog sense.
    input wire logic i_port_sel,
    input wire logic i_otg,
    input wire logic [2:0] i_current_limit_pin,
    input wire cps_sense_t i_sense,
    // Outputs.
    output cps_drive_t o_drive,
    output logic o_input_good_output_n,
    output logic o_int
);
    initial begin
        if (TICK_CYCLES < 2) $error("TICK_CYCLES too small");
    end

    typedef enum logic [6:0] {
        CPS_HIZ = 7'h01,
        CPS_BIAS = 7'h02,
        CPS_QUAL = 7'h04,
        CPS_RETRY = 7'h08,
        CPS_DET = 7'h10,
        CPS_RUN = 7'h20,
        CPS_BOOST = 7'h40
    } cps_state_t;

    cps_state_t state_r, state_nxt;
    logic [31:0] div_r;
    logic tick;
    logic [11:0] tmr_r;
    logic tmr_clr;
    logic hiz_r, host_mode_r, force_r, pg_r, int_r;
    logic [1:0] src_r, chg_cfg_r;
    logic [2:0] current_limit_pin_r, sys_min_r;
    logic [3:0] vin_lim_r, boost_voltage_field_r;
    logic [1:0] temp_band_r;
    logic boost_1a5_r, sup_r;
    logic [7:0] fault_r;

    // One slow tick keeps every delay on a single time base.
    assign tick = (div_r == 32'(TICK_CYCLES - 1));
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || tick) div_r <= 32'h0;
        else div_r <= div_r + 32'h1;
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || tmr_clr) tmr_r <= 12'h0;
        else if (tick && tmr_r != 12'hFFF) tmr_r <= tmr_r + 12'h1;
    end

    wire bias_ok = i_sense.uvlo_ok && i_sense.above_sleep;
    wire qual_ok = i_sense.below_ovp && i_sense.src_good;
    wire boost_req = i_otg && (chg_cfg_r == CHG_CFG_BOOST);
    wire boost_ok = i_sense.bat_above_low && !i_sense.above_sleep && boost_req
        && (i_sense.temp_ok || temp_band_r == TEMP_BAND_OFF);
    wire wr0 = i_wr && i_addr == ADDR_CTRL0;
    wire wr7 = i_wr && i_addr == ADDR_MISC;
    wire host_clr_hiz = wr0 && !i_wdata[HIZ_BIT];
    wire redetect = force_r || i_sense.watchdog_to;
    wire [2:0] det_lim = !i_port_sel ? CURRENT_LIMIT_PIN_3A : (i_otg ? CURRENT_LIMIT_PIN_500 : CURRENT_LIMIT_PIN_100);
    wire [1:0] det_src = !i_port_sel ? SRC_ADAPTER : SRC_USB;
    wire det_hiz = i_port_sel && !i_otg && i_sense.bat_good;
    wire dly_bias = tmr_r >= 12'(BIAS_DLY_MS);
    wire dly_retry = tmr_r >= 12'(RETRY_MS);
    wire dly_boost = tmr_r >= 12'(BOOST_DLY_MS);
    wire dly_det = tmr_r >= 12'(DET_MS);
    wire rd_fault = i_rd && i_addr == ADDR_FAULT;
    wire pg_rise = (state_r == CPS_QUAL) && qual_ok;

    always_comb begin
        state_nxt = state_r;
        tmr_clr = 1'b0;
        case (state_r)
            CPS_HIZ: begin
                // Host-mode high-impedance holds until the host clears the bit or a watchdog timeout ends host mode; a boost request leaves it.
                if (boost_req) begin
                    state_nxt = CPS_BOOST;
                    tmr_clr = 1'b1;
                end else if (bias_ok && !(hiz_r && host_mode_r)) begin
                    state_nxt = CPS_BIAS;
                    tmr_clr = 1'b1;
                end
            end
            CPS_BIAS: begin
                if (!bias_ok) state_nxt = CPS_HIZ;
                else if (dly_bias) state_nxt = CPS_QUAL;
            end
            CPS_QUAL: begin
                tmr_clr = 1'b1;
                if (!bias_ok) state_nxt = CPS_HIZ;
                else if (qual_ok) state_nxt = CPS_DET;
                else state_nxt = CPS_RETRY;
            end
            CPS_RETRY: begin
                if (!bias_ok) state_nxt = CPS_HIZ;
                else if (dly_retry) state_nxt = CPS_QUAL;
            end
            CPS_DET: begin
                if (!bias_ok) state_nxt = CPS_HIZ;
                else if (dly_det) state_nxt = det_hiz ? CPS_HIZ : CPS_RUN;
            end
            CPS_RUN: begin
                if (!bias_ok || !i_sense.below_ovp) state_nxt = CPS_HIZ;
                else if (redetect) begin
                    state_nxt = CPS_DET;
                    tmr_clr = 1'b1;
                end
            end
            CPS_BOOST: begin
                if (!boost_req) state_nxt = CPS_HIZ;
            end
            default: state_nxt = CPS_HIZ;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) state_r <= CPS_HIZ;
        else state_r <= state_nxt;
    end

    // Control and detection results; detection wins over a host limit write in the same cycle.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            hiz_r <= 1'b0;
            host_mode_r <= 1'b0;
            current_limit_pin_r <= CURRENT_LIMIT_PIN_RST;
            vin_lim_r <= VIN_LIM_RST;
            src_r <= SRC_UNKNOWN;
            force_r <= 1'b0;
        end else begin
            if (i_sense.watchdog_to) host_mode_r <= 1'b0;
            else if (i_wr) host_mode_r <= 1'b1;
            if (state_r == CPS_DET && state_nxt != CPS_DET && bias_ok) begin
                src_r <= det_src;
                current_limit_pin_r <= det_lim;
                if (det_hiz) hiz_r <= 1'b1;
                force_r <= 1'b0;
            end else begin
                if (wr0) begin
                    hiz_r <= i_wdata[HIZ_BIT];
                    vin_lim_r <= i_wdata[6:3];
                    current_limit_pin_r <= i_wdata[2:0];
                end else if (!i_sense.uvlo_ok && !host_mode_r) begin
                    hiz_r <= 1'b0;
                end
                if (wr7 && i_wdata[FORCE_DET_BIT]) force_r <= 1'b1;
                if (state_nxt == CPS_BOOST) src_r <= SRC_OTG;
                else if (!i_sense.uvlo_ok) src_r <= SRC_UNKNOWN;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            chg_cfg_r <= CHG_CFG_RST;
            sys_min_r <= SYSMIN_RST;
            boost_1a5_r <= 1'b0;
            boost_voltage_field_r <= BOOST_VOLTAGE_FIELD_RST;
            temp_band_r <= 2'h0;
        end else begin
            if (i_wr && i_addr == ADDR_CFG1) begin
                chg_cfg_r <= i_wdata[5:4];
                sys_min_r <= i_wdata[3:1];
                boost_1a5_r <= i_wdata[0];
            end
            if (i_wr && i_addr == ADDR_BOOST) begin
                boost_voltage_field_r <= i_wdata[7:4];
                temp_band_r <= i_wdata[1:0];
            end
        end
    end

    // Fault latch: a new event wins over the clear-on-read.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            fault_r <= 8'h00;
            pg_r <= 1'b0;
            int_r <= 1'b0;
            sup_r <= 1'b0;
        end else begin
            if (rd_fault) fault_r <= 8'h00;
            if (state_r == CPS_BOOST && i_sense.boost_fault)
                fault_r[FLT_BOOST_BIT] <= 1'b1;
            if (state_r == CPS_QUAL && !i_sense.src_good)
                fault_r[FLT_IN_LSB] <= 1'b1;
            if (pg_rise) pg_r <= 1'b1;
            else if (state_r == CPS_HIZ || state_r == CPS_BIAS) pg_r <= 1'b0;
            int_r <= pg_rise || (state_r == CPS_BOOST && i_sense.boost_fault);
            if (i_sense.sys_below_bat) sup_r <= 1'b1;
            else if (i_sense.bat_depleted) sup_r <= 1'b0;
        end
    end

    wire in_conv = (state_r == CPS_RUN) || (state_r == CPS_DET);
    wire power_limit_loop = in_conv && (i_sense.over_input_i || i_sense.below_vin_lim);
    wire [2:0] reg_pin_min = (current_limit_pin_r < i_current_limit_pin) ? current_limit_pin_r : i_current_limit_pin;
    wire [2:0] current_limit_pin_eff = (state_r == CPS_DET || !i_sense.sys_above_2v2)
        ? CURRENT_LIMIT_PIN_100 : reg_pin_min;
    wire [7:0] ctrl0 = {hiz_r, vin_lim_r, current_limit_pin_r};
    wire [7:0] status = {src_r, 2'h0, power_limit_loop, pg_r, 1'b0, i_sense.at_sys_min};
    wire [7:0] cfg1 = {2'h0, chg_cfg_r, sys_min_r, boost_1a5_r};

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) o_rdata <= 8'h00;
        else if (i_rd) begin
            case (i_addr)
                ADDR_CTRL0: o_rdata <= ctrl0;
                ADDR_CFG1: o_rdata <= cfg1;
                ADDR_BOOST: o_rdata <= {boost_voltage_field_r, 2'h0, temp_band_r};
                ADDR_MISC: o_rdata <= {force_r, 7'h00};
                ADDR_STATUS: o_rdata <= status;
                ADDR_FAULT: o_rdata <= fault_r;
                default: o_rdata <= 8'h00;
            endcase
        end
    end

    always_comb begin
        o_drive.bias_en = !(state_r == CPS_HIZ || state_r == CPS_BIAS);
        o_drive.test_load = state_r == CPS_QUAL;
        o_drive.conv_en = state_r == CPS_RUN;
        o_drive.boost_en = state_r == CPS_BOOST && dly_boost && boost_ok;
        o_drive.batt_sw_on = (state_r == CPS_RUN) ? (i_sense.charge_en || sup_r) : 1'b1;
        o_drive.boost_1a5 = boost_1a5_r;
        o_drive.boost_v = boost_voltage_field_r;
        o_drive.sys_min = sys_min_r;
        o_drive.current_limit_pin_eff = current_limit_pin_eff;
        o_drive.vin_lim = vin_lim_r;
        o_drive.cut_charge = power_limit_loop;
    end
    assign o_input_good_output_n = !pg_r;
    assign o_int = int_r;

    bias_hiz_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !bias_ok |=> !o_drive.bias_en || state_r == CPS_BOOST)
        else $error("bias on with failing condition");
    pg_int_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pg_rise |=> pg_r && int_r && !o_input_good_output_n)
        else $error("input good not reported");
    det_limit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_DET |-> o_drive.current_limit_pin_eff == CURRENT_LIMIT_PIN_100)
        else $error("detection limit not forced");
    soft_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_sense.sys_above_2v2 |-> o_drive.current_limit_pin_eff == CURRENT_LIMIT_PIN_100)
        else $error("soft start limit wrong");
    hiz_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_HIZ && hiz_r && host_mode_r && !boost_req |=> state_r == CPS_HIZ)
        else $error("left host high impedance");
    boost_type_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_BOOST && $past(state_r) == CPS_BOOST |-> src_r == SRC_OTG)
        else $error("boost source type wrong");
    boost_fault_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_BOOST && i_sense.boost_fault |=> fault_r[FLT_BOOST_BIT] && o_int)
        else $error("boost fault not latched");
    dpm_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_drive.cut_charge |-> in_conv && (i_sense.over_input_i || i_sense.below_vin_lim))
        else $error("power limit flag wrong");
    boost_cond_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_drive.boost_en |-> boost_req && i_sense.bat_above_low && tmr_r >= 12'(BOOST_DLY_MS))
        else $error("boost started early");

    // Sequencer timing: bias and retry waits hold until their delays run out; poor source refused, converter stopped.
    bias_delay_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_BIAS && bias_ok && !dly_bias |=> state_r == CPS_BIAS)
        else $error("bias delay cut short");
    qual_fail_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_QUAL && bias_ok && !qual_ok |=> state_r == CPS_RETRY)
        else $error("poor source not refused");
    retry_wait_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_RETRY && bias_ok && !dly_retry |=> state_r == CPS_RETRY)
        else $error("retry interval cut short");
    conv_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_RUN && (!bias_ok || !i_sense.below_ovp) |=> !o_drive.conv_en)
        else $error("converter kept running");

    // Detection results and the control bit they touch.
    det_result_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_DET && state_nxt == CPS_RUN
        |=> src_r == $past(det_src) && current_limit_pin_r == $past(det_lim))
        else $error("detection result not stored");
    det_hiz_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_DET && state_nxt == CPS_HIZ && bias_ok |=> hiz_r)
        else $error("high impedance bit not set");
    force_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_DET && state_nxt != CPS_DET && bias_ok |=> !force_r)
        else $error("force bit not cleared");
    default_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_sense.uvlo_ok && !host_mode_r && !wr0 |=> !hiz_r)
        else $error("control bit kept on removal");

    // Power path, boost exit and the fault latch.
    batt_sw_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_RUN && !i_sense.charge_en && !sup_r |-> !o_drive.batt_sw_on)
        else $error("battery switch on while disabled");
    supp_on_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_sense.sys_below_bat |=> sup_r)
        else $error("supplement mode not entered");
    boost_exit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state_r == CPS_BOOST && !boost_req |=> state_r == CPS_HIZ)
        else $error("boost kept without request");
    fault_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        fault_r[FLT_BOOST_BIT] && !rd_fault |=> fault_r[FLT_BOOST_BIT])
        else $error("fault bit lost");
    fault_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_fault && !(state_r == CPS_BOOST && i_sense.boost_fault)
        && !(state_r == CPS_QUAL && !i_sense.src_good) |=> fault_r == 8'h00)
        else $error("fault read did not clear");
endmodule

//--- test/cps_src_model.sv
// Far side of the port-type pins: the phy select output and the otg pin.
// Assumes the bench picks the port kind; detached, the select line holds no stale level.
`timescale 1ns/1ps
module cps_src_model #(
    parameter int SETTLE = 3
) (
    // Clock.
    input wire logic i_clk_sys,
    // Bench commands.
    input wire logic i_attach,
    input wire logic [1:0] i_kind,
    input wire logic i_otg_req,
    // Pins.
    output logic o_port_sel,
    output logic o_otg
);
    int wait_r = 0;
    logic toggle_r = 1'b0;
    // The phy reports its type only some cycles after attach, so early looks see noise.
    always @(posedge i_clk_sys) begin
        toggle_r <= ~toggle_r;
        wait_r <= i_attach ? (wait_r < SETTLE ? wait_r + 1 : wait_r) : 0;
    end
    assign o_port_sel = (i_attach && wait_r == SETTLE) ? ~i_kind[1] : toggle_r;
    assign o_otg = i_attach ? i_kind[0] : i_otg_req;
endmodule

//--- test/tb_cps_seq.sv
// Bench for the input power sequencer: a register and pin model against the design.
// Assumes a four-cycle time base tick so the long delays stay short.
`timescale 1ns/1ps
module tb_cps_seq;
    import cps_pkg::*;
    localparam int TK = 4;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic [2:0] i_current_limit_pin = 3'h7;
    cps_sense_t i_sense = '0;
    cps_drive_t o_drive;
    logic o_input_good_output_n, o_int, port_sel, otg;
    logic attach = 1'b0;
    logic otg_req = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [7:0] mreg [16] = '{default: 8'h00};
    logic [3:0] amap [7] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'h8, 4'h9, 4'hF};
    int n_mismatch = 0;
    int num_checks = 0;
    int n_int = 0;
    int cyc = 0;
    int n, k, p, v;
    cps_seq #(.TICK_CYCLES(TK)) dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_sel(port_sel),
        .i_otg(otg), .i_current_limit_pin(i_current_limit_pin), .i_sense(i_sense),
        .o_drive(o_drive), .o_input_good_output_n(o_input_good_output_n), .o_int(o_int));
    cps_src_model #(.SETTLE(3)) src_u (.i_clk_sys(i_clk_sys), .i_attach(attach),
        .i_kind(kind), .i_otg_req(otg_req), .o_port_sel(port_sel), .o_otg(otg));
    initial begin
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    task automatic test_done();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        n_int <= n_int + int'(o_int === 1'b1);
        if (cyc == 30000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        if (a inside {ADDR_CTRL0, ADDR_CFG1, ADDR_BOOST}) mreg[a] = d;
    endtask
    // Read data appear in the cycle after the strobe and hold until the next read, so they are sampled there.
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata & m, exp & m);
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge i_clk_sys);
        #1;
    endtask
    function automatic logic hit(input int w);
        return w == 0 ? o_drive.bias_en === 1'b1 : w == 1 ? o_input_good_output_n === 1'b0
            : o_drive.boost_en === 1'b1;
    endfunction
    task automatic waitfor(input int w, input int lim);
        n = 0;
        while (n < lim && !hit(w)) begin
            tick(1);
            n++;
        end
    endtask
    initial begin
        mreg[0] = 8'h30;
        mreg[1] = 8'h1A;
        mreg[6] = 8'h70;
        v = $urandom(652);
        i_sense.below_ovp <= 1'b1;
        i_sense.src_good <= 1'b1;
        i_sense.temp_ok <= 1'b1;
        tick(16);
        i_rst <= 1'b0;
        tick(1);
        for (k = 0; k < 7; k++) rd(amap[k], mreg[amap[k]], 8'hFF);
        i_sense.uvlo_ok <= 1'b1;
        i_sense.above_sleep <= 1'b1;
        attach <= 1'b1;
        kind <= 2'h2;
        waitfor(0, 1200);
        chk(8'(n >= TK * (BIAS_DLY_MS - 2) && n <= TK * (BIAS_DLY_MS + 2)), 8'h01);
        k = n_int;
        waitfor(1, 40);
        chk(8'(hit(1)), 8'h01);
        tick(TK * DET_MS + 8);
        chk(8'(n_int - k), 8'h01);
        rd(ADDR_STATUS, {SRC_ADAPTER, 6'h04}, 8'hFF);
        i_sense.sys_above_2v2 <= 1'b1;
        for (k = 0; k < 4; k++) begin
            kind <= 2'(k);
            tick(6);
            if (k == 0) begin
                i_sense.watchdog_to <= 1'b1;
                tick(1);
                i_sense.watchdog_to <= 1'b0;
            end else begin
                wr(ADDR_MISC, 8'h80);
            end
            tick(1);
            chk(8'(o_drive.current_limit_pin_eff), 8'(CURRENT_LIMIT_PIN_100));
            tick(TK * DET_MS + 8);
            mreg[0][2:0] = k > 1 ? CURRENT_LIMIT_PIN_3A : k == 1 ? CURRENT_LIMIT_PIN_500 : CURRENT_LIMIT_PIN_100;
            rd(ADDR_STATUS, {k > 1 ? SRC_ADAPTER : SRC_USB, 6'h04}, 8'hFF);
            rd(ADDR_CTRL0, mreg[0], 8'hFF);
            rd(ADDR_MISC, 8'h00, 8'h80);
        end
        v = $urandom;
        p = $urandom % 8;
        i_current_limit_pin <= 3'(p);
        i_sense.sys_above_2v2 <= 1'b0;
        wr(ADDR_CTRL0, {1'b0, 7'(v)});
        rd(ADDR_CTRL0, mreg[0], 8'hFF);
        chk(8'(o_drive.current_limit_pin_eff), 8'(CURRENT_LIMIT_PIN_100));
        i_sense.sys_above_2v2 <= 1'b1;
        tick(1);
        chk(8'(o_drive.current_limit_pin_eff), 8'(v[2:0] < p ? v[2:0] : p));
        chk({o_drive.vin_lim, 1'b0, o_drive.conv_en, o_drive.batt_sw_on, o_drive.cut_charge},
            {v[6:3], 4'h4});
        chk(8'(o_drive.sys_min), 8'(SYSMIN_RST));
        i_sense.over_input_i <= 1'b1;
        i_sense.at_sys_min <= 1'b1;
        i_sense.sys_below_bat <= 1'b1;
        rd(ADDR_STATUS, 8'h09, 8'h09);
        chk({o_drive.cut_charge, o_drive.batt_sw_on}, 8'h03);
        i_sense.over_input_i <= 1'b0;
        i_sense.below_vin_lim <= 1'b1;
        i_sense.sys_below_bat <= 1'b0;
        i_sense.bat_depleted <= 1'b1;
        tick(2);
        chk({o_drive.cut_charge, o_drive.batt_sw_on}, 8'h02);
        i_sense <= '{uvlo_ok: 1, above_sleep: 1, below_ovp: 1, sys_above_2v2: 1, charge_en: 1,
            temp_ok: 1, default: 0};
        tick(2);
        chk(8'(o_drive.batt_sw_on), 8'h01);
        i_sense.uvlo_ok <= 1'b0;
        tick(3);
        chk({o_drive.bias_en, o_drive.conv_en}, 8'h00);
        i_sense.uvlo_ok <= 1'b1;
        waitfor(0, 1200);
        tick(20);
        rd(ADDR_FAULT, 8'h10, 8'h10);
        rd(ADDR_FAULT, 8'h00, 8'h10);
        chk(8'(o_input_good_output_n), 8'h01);
        i_sense.src_good <= 1'b1;
        waitfor(1, 9000);
        chk(8'(n >= TK * (RETRY_MS - 12) && n <= TK * RETRY_MS), 8'h01);
        i_sense.bat_good <= 1'b1;
        kind <= 2'h0;
        tick(20);
        wr(ADDR_MISC, 8'h80);
        tick(TK * DET_MS + 8);
        chk(8'(o_drive.bias_en), 8'h00);
        rd(ADDR_CTRL0, 8'h80, 8'h80);
        tick(200);
        rd(ADDR_CTRL0, 8'h80, 8'h80);
        i_sense.uvlo_ok <= 1'b0;
        i_sense.above_sleep <= 1'b0;
        attach <= 1'b0;
        wr(ADDR_CTRL0, 8'h30);
        rd(ADDR_CTRL0, 8'h30, 8'hFF);
        otg_req <= 1'b1;
        i_sense.bat_above_low <= 1'b1;
        wr(ADDR_BOOST, 8'hA0);
        rd(ADDR_BOOST, 8'hA0, 8'hFF);
        wr(ADDR_CFG1, 8'h2B);
        waitfor(2, 400);
        chk(8'(n >= TK * (BOOST_DLY_MS - 2) && n <= TK * (BOOST_DLY_MS + 2)), 8'h01);
        chk({o_drive.boost_v, 3'h0, o_drive.boost_1a5}, 8'hA1);
        rd(ADDR_STATUS, {SRC_OTG, 6'h00}, 8'hC0);
        k = n_int;
        i_sense.boost_fault <= 1'b1;
        tick(1);
        i_sense.boost_fault <= 1'b0;
        tick(4);
        chk(8'(n_int - k), 8'h01);
        rd(ADDR_FAULT, 8'h40, 8'h40);
        test_done();
    end
endmodule
